/* design/romif_ctrl.sv */
`timescale 1ns/10ps
module romif_ctrl (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // rom pins
   output logic             rom_select_n,
   output logic      [28:0] latched_address_bus,
   input  wire logic [31:0] rom_data_in
);

   // -------------------------------------------------
   // declarations
   // -------------------------------------------------
   romif_pkg::romif_state_e st;

   logic [31:0] data_meta;
   logic [31:0] data_sync;

   logic [7:0]  cfg_value   [2];
   logic [4:0]  cfg_nseq    [2];
   logic [4:0]  cfg_burst   [2];
   logic        cfg_burst_en[2];
   logic        cfg_wide    [2];
   logic        cfg_we      [2];

   logic        addr_phase;
   logic        in_rom;
   logic        hit_cfg0;
   logic        hit_cfg1;
   logic        hit_stat;
   logic        rom_read;
   logic        req_bank;
   logic        req_wide;
   logic        seq_hit;
   logic [4:0]  req_cycles;
   logic [28:0] req_addr;
   logic [7:0]  fwd_byte;
   logic [31:0] reg_rdata;

   localparam int CNT_WIDTH = romif_pkg::CNT_W;
   logic [CNT_WIDTH-1:0] cnt;

   logic        cur_bank;
   logic        cur_wide;
   logic        half_sel;
   logic [15:0] low_half;
   logic        fetch_start;
   logic        fetch_last;
   logic        fetch_final;
   logic [31:0] fetch_word;
   logic [4:0]  second_cycles;

   logic        chain_valid;
   logic        chain_bank;
   logic [26:0] chain_word;
   logic [2:0]  chain_len;
   logic        cur_seq;
   logic        last_seq;

   logic        wr_pend;
   logic        wr_sel;

   // -------------------------------------------------
   // rom data synchroniser
   // -------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_meta <= 32'h0000_0000;
         data_sync <= 32'h0000_0000;
      end else begin
         data_meta <= rom_data_in;
         data_sync <= data_meta;
      end
   end

   // -------------------------------------------------
   // bank configuration registers
   // -------------------------------------------------
   // R10 - bank register write decode
   assign cfg_we[0] = wr_pend && !wr_sel;
   assign cfg_we[1] = wr_pend && wr_sel;

   romif_bank_cfg u_bank0 (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .wr_en        (cfg_we[0]),
      .wr_data      (hwdata[7:0]),
      .value        (cfg_value[0]),
      .nseq_cycles  (cfg_nseq[0]),
      .burst_cycles (cfg_burst[0]),
      .burst_en     (cfg_burst_en[0]),
      .wide16       (cfg_wide[0])
   );

   romif_bank_cfg u_bank1 (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .wr_en        (cfg_we[1]),
      .wr_data      (hwdata[7:0]),
      .value        (cfg_value[1]),
      .nseq_cycles  (cfg_nseq[1]),
      .burst_cycles (cfg_burst[1]),
      .burst_en     (cfg_burst_en[1]),
      .wide16       (cfg_wide[1])
   );

   // -------------------------------------------------
   // address phase decode
   // -------------------------------------------------
   assign addr_phase = hsel && hready && htrans[1];
   // R1 - rom range, base is zero
   assign in_rom     = (haddr <= romif_pkg::ROM_TOP);
   assign hit_cfg0   = (haddr == romif_pkg::BANK0_CFG_ADDR);
   assign hit_cfg1   = (haddr == romif_pkg::BANK1_CFG_ADDR);
   assign hit_stat   = (haddr == romif_pkg::FETCH_STAT_ADDR);
   // R2 - writes never start fetch
   assign rom_read   = addr_phase && in_rom && !hwrite;
   assign req_bank   = haddr[romif_pkg::BANK_SEL_BIT];
   assign req_wide   = cfg_wide[req_bank];

   // R4 - next word within quad
   assign seq_hit = chain_valid && !req_wide
                    && cfg_burst_en[req_bank]
                    && (chain_bank == req_bank)
                    && (haddr[28:2] == chain_word + 27'h1)
                    && (haddr[3:2] != 2'h0);

   assign req_cycles = seq_hit ? cfg_burst[req_bank] : cfg_nseq[req_bank];

   always_comb begin
      // R8 - shift for 16-bit banks
      if (req_wide) begin
         req_addr = {haddr[27:2], 1'b0, 2'h0};
      end else begin
         req_addr = {haddr[28:2], 2'h0};
      end
   end

   // -------------------------------------------------
   // register read data
   // -------------------------------------------------
   assign fwd_byte = hwdata[7:0];

   always_comb begin
      reg_rdata = 32'h0000_0000;
      if (hit_cfg0) begin
         reg_rdata[7:0] = (wr_pend && !wr_sel) ? fwd_byte : cfg_value[0];
      end else if (hit_cfg1) begin
         reg_rdata[7:0] = (wr_pend && wr_sel) ? fwd_byte : cfg_value[1];
      end else if (hit_stat) begin
         reg_rdata[5:0] = {last_seq, chain_len, cfg_wide[chain_bank],
                           chain_bank};
      end
   end

   // -------------------------------------------------
   // pending register write
   // -------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_sel  <= 1'b0;
      end else begin
         wr_pend <= addr_phase && hwrite && (hit_cfg0 || hit_cfg1);
         wr_sel  <= hit_cfg1;
      end
   end

   // -------------------------------------------------
   // fetch sequencing
   // -------------------------------------------------
   assign fetch_last  = (st == romif_pkg::ST_FETCH) && (cnt == 5'h01);
   // R5 - two fetches when 16-bit
   assign fetch_final = fetch_last && (!cur_wide || half_sel);

   // R7 - burst timing second half
   // R6 - else non-sequential again
   assign second_cycles = cfg_burst_en[cur_bank] ? cfg_burst[cur_bank]
                                                 : cfg_nseq[cur_bank];

   // R9 - lower address gives low half
   assign fetch_word = cur_wide ? {data_sync[15:0], low_half} : data_sync;

   // -------------------------------------------------
   // fetch state
   // -------------------------------------------------
   assign fetch_start = (st == romif_pkg::ST_IDLE) && rom_read;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= romif_pkg::ST_IDLE;
      end else begin
         case (st)
            romif_pkg::ST_IDLE: begin
               if (rom_read) begin
                  st <= romif_pkg::ST_FETCH;
               end
            end
            romif_pkg::ST_FETCH: begin
               if (fetch_final) begin
                  st <= romif_pkg::ST_IDLE;
               end
            end
            default: begin
               st <= romif_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // -------------------------------------------------
   // access time counter
   // -------------------------------------------------
   // two extra cycles cover the data synchroniser
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 5'h00;
      end else if (fetch_start) begin
         cnt <= req_cycles + romif_pkg::SYNC_STAGES;
      end else if (fetch_final) begin
         cnt <= 5'h00;
      end else if (fetch_last) begin
         cnt <= second_cycles + romif_pkg::SYNC_STAGES;
      end else if (st == romif_pkg::ST_FETCH) begin
         cnt <= cnt - 5'h01;
      end
   end

   // -------------------------------------------------
   // transfer context
   // -------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_bank <= 1'b0;
         cur_wide <= 1'b0;
         cur_seq  <= 1'b0;
      end else if (fetch_start) begin
         cur_bank <= req_bank;
         cur_wide <= req_wide;
         cur_seq  <= seq_hit;
      end
   end

   // -------------------------------------------------
   // halfword assembly
   // -------------------------------------------------
   // R6 - hold first halfword
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         half_sel <= 1'b0;
         low_half <= 16'h0000;
      end else if (fetch_start) begin
         half_sel <= 1'b0;
      end else if (fetch_last && !fetch_final) begin
         half_sel <= 1'b1;
         low_half <= data_sync[15:0];
      end
   end

   // -------------------------------------------------
   // rom chip select
   // -------------------------------------------------
   // R1 - select for rom reads
   // select stays low across both halfwords
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rom_select_n <= 1'b1;
      end else if (fetch_start) begin
         rom_select_n <= 1'b0;
      end else if (fetch_final) begin
         rom_select_n <= 1'b1;
      end
   end

   // -------------------------------------------------
   // latched rom address
   // -------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         latched_address_bus <= 29'h0000_0000;
      end else if (fetch_start && seq_hit) begin
         // R4 - step low two bits
         latched_address_bus[3:2] <= latched_address_bus[3:2] + 2'h1;
      end else if (fetch_start) begin
         latched_address_bus <= req_addr;
      end else if (fetch_last && !fetch_final) begin
         latched_address_bus[2] <= 1'b1;
      end
   end

   // -------------------------------------------------
   // burst chain tracking
   // -------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chain_valid <= 1'b0;
         chain_bank  <= 1'b0;
         chain_word  <= 27'h000_0000;
         chain_len   <= 3'h0;
         last_seq    <= 1'b0;
      end else if (fetch_final) begin
         chain_valid <= 1'b1;
         chain_bank  <= cur_bank;
         chain_word  <= cur_wide ? {1'b0, latched_address_bus[28:3]}
                                 : latched_address_bus[28:2];
         chain_len   <= cur_seq ? chain_len + 3'h1 : 3'h1;
         last_seq    <= cur_seq;
      end else if (addr_phase && !rom_read) begin
         // any other access breaks the chain
         chain_valid <= 1'b0;
      end
   end

   // -------------------------------------------------
   // ahb response
   // -------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else begin
         hresp <= 1'b0;
         if (fetch_final) begin
            hreadyout <= 1'b1;
            hrdata    <= fetch_word;
         end else if (rom_read) begin
            hreadyout <= 1'b0;
         end else if (addr_phase) begin
            hreadyout <= 1'b1;
            hrdata    <= hwrite ? 32'h0000_0000 : reg_rdata;
         end
      end
   end

   // -------------------------------------------------
   // unused transfer size
   // -------------------------------------------------
   // all widths accepted; config takes byte lane 0
   logic size_unused;
   assign size_unused = |hsize;

endmodule

/* design/romif_pkg.sv */
// What this block does
// R1 - select only in ROM address range
// R2 - writes to ROM never assert select
// R3 - half speed bit zero doubles times
// R4 - burst increments low two address bits
// R5 - width bit gives two fetches per word
// R6 - no burst: two non-sequential halfword fetches
// R7 - burst: second halfword uses burst timing
// R8 - 16-bit address shifted up one bit
// R9 - lower address halfword forms low bits
// R10 - two byte addresses reach bank registers
// R11 - non-sequential codes map seven down two
// R12 - burst codes: off, four, three, two
// R13 - bit 6 width; fields read back
// R14 - reset value 0x40 in both banks
// R15 - unlisted non-sequential codes mean seven
package romif_pkg;

   // -------------------------------------------------
   // address map
   // -------------------------------------------------
   localparam logic [31:0] ROM_TOP         = 32'h01ff_ffff;
   localparam logic [31:0] BANK0_CFG_ADDR  = 32'h0320_0080;
   localparam logic [31:0] BANK1_CFG_ADDR  = 32'h0320_0084;
   localparam logic [31:0] FETCH_STAT_ADDR = 32'h0320_0088;
   localparam int          BANK_SEL_BIT    = 24;

   // -------------------------------------------------
   // bank register fields
   // -------------------------------------------------
   localparam logic [7:0] CFG_RESET  = 8'h40;
   localparam int         NSEQ_LSB   = 0;
   localparam int         NSEQ_MSB   = 2;
   localparam int         BURST_LSB  = 3;
   localparam int         BURST_MSB  = 4;
   localparam int         HALF_BIT   = 5;
   localparam int         WIDTH_BIT  = 6;

   // -------------------------------------------------
   // timing counts in memory clock cycles
   // -------------------------------------------------
   localparam int         CNT_W          = 5;
   localparam logic [2:0] NSEQ_LAST_CODE = 3'h5;
   localparam logic [4:0] NSEQ_MAX_CYC   = 5'h07;
   localparam logic [4:0] BURST_BASE_CYC = 5'h05;
   localparam logic [4:0] SYNC_STAGES    = 5'h02;
   localparam int         LA_W           = 29;

   // -------------------------------------------------
   // fetch sequencer states
   // -------------------------------------------------
   typedef enum logic [0:0] {
      ST_IDLE  = 1'b0,
      ST_FETCH = 1'b1
   } romif_state_e;

endpackage

/* design/romif_bank_cfg.sv */
`timescale 1ns/10ps
module romif_bank_cfg (
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // register write
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   // decoded configuration
   output logic      [7:0] value,
   output logic      [4:0] nseq_cycles,
   output logic      [4:0] burst_cycles,
   output logic            burst_en,
   output logic            wide16
);

   logic [2:0] nseq_code;
   logic [1:0] burst_code;
   logic [4:0] nseq_base;
   logic [4:0] burst_base;

   // R14 - reset value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         value <= romif_pkg::CFG_RESET;
      end else if (wr_en) begin
         value <= wr_data;
      end
   end

   always_comb begin
      nseq_code  = value[romif_pkg::NSEQ_MSB:romif_pkg::NSEQ_LSB];
      burst_code = value[romif_pkg::BURST_MSB:romif_pkg::BURST_LSB];
      // R11 - code to cycles
      // R15 - unlisted codes slowest
      if (nseq_code > romif_pkg::NSEQ_LAST_CODE) begin
         nseq_base = romif_pkg::NSEQ_MAX_CYC;
      end else begin
         nseq_base = romif_pkg::NSEQ_MAX_CYC - {2'h0, nseq_code};
      end
      // R12 - burst code decode
      burst_base = romif_pkg::BURST_BASE_CYC - {3'h0, burst_code};
      burst_en   = (burst_code != 2'h0);
      // R13 - width select bit
      wide16     = value[romif_pkg::WIDTH_BIT];
      // R3 - half speed doubling
      if (value[romif_pkg::HALF_BIT]) begin
         nseq_cycles  = nseq_base;
         burst_cycles = burst_base;
      end else begin
         nseq_cycles  = {nseq_base[3:0], 1'b0};
         burst_cycles = {burst_base[3:0], 1'b0};
      end
   end

endmodule

/* test/romif_rom_model.sv */
`timescale 1ns/10ps
// ----
// rom device model
// ----
module romif_rom_model (
   // clock
   input  wire logic        hclk,
   // rom pins
   input  wire logic        rom_select_n,
   input  wire logic [28:0] latched_address_bus,
   output logic      [31:0] rom_data_in
);
   logic [31:0] held = 32'h0;
   logic [31:0] word;
   assign word = {~latched_address_bus[17:2], latched_address_bus[17:2]};
   always @(posedge hclk) if (!rom_select_n) held <= word;
   // released bus shows inverse of last word
   assign rom_data_in = rom_select_n ? ~held : word;
endmodule

/* test/romif_ctrl_checker.sv */
`timescale 1ns/10ps
// ----
// port checks
// ----
module romif_ctrl_checker (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   // rom pins
   input wire logic        rom_select_n
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   logic wr_req;
   logic rd_rom;
   assign wr_req = hsel && hready && htrans[1] && hwrite;
   assign rd_rom = hsel && hready && htrans[1] && !hwrite && haddr <= romif_pkg::ROM_TOP;
   a_select_in_range: assert property ($fell(rom_select_n) |-> $past(rd_rom))
      else $error("select without rom read");
   a_stall_cause: assert property ($fell(hreadyout) |-> $past(rd_rom))
      else $error("stall without rom read");
   a_write_no_select: assert property (wr_req |=> rom_select_n ##1 rom_select_n)
      else $error("select on write");
   a_write_no_stall: assert property (wr_req |=> hreadyout)
      else $error("write stalled");
   a_select_stalls_bus: assert property (!rom_select_n |-> !hreadyout)
      else $error("ready during fetch");
   a_fetch_min_len: assert property ($fell(rom_select_n) |-> !rom_select_n [*4])
      else $error("fetch too short");
   a_fetch_bounded: assert property ($fell(rom_select_n) |-> ##[4:40] $rose(rom_select_n))
      else $error("fetch too long");
   a_answer_on_release: assert property ($rose(rom_select_n) |-> ##[0:1] hreadyout)
      else $error("no answer after fetch");
endmodule

/* test/romif_ctrl_test.sv */
`timescale 1ns/10ps
module romif_ctrl_test;
   // ----
   // signals
   // ----
   logic        hclk = 1'b0;
   logic        hresetn, hsel, hwrite, hreadyout, hresp, rom_select_n, chain;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rom_data_in, r, a, v, prev;
   logic [28:0] latched_address_bus;
   logic [7:0]  cfg [2];
   int          mismatches, n_compared, seed, n;
   romif_ctrl romif_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rom_select_n(rom_select_n),
      .latched_address_bus(latched_address_bus), .rom_data_in(rom_data_in));
   romif_rom_model romif_rom_model_inst (.hclk(hclk), .rom_select_n(rom_select_n),
      .latched_address_bus(latched_address_bus), .rom_data_in(rom_data_in));
   always #5 hclk = ~hclk;
   // ----
   // helpers
   // ----
   task finish_test;
      if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task xfer(input logic w, input logic [31:0] ad, input logic [31:0] d,
             output logic [31:0] rd, output int cnt);
      int k;
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= ad;
      hwrite <= w;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 200);
      htrans <= 2'b00;
      hwdata <= d;
      cnt = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && cnt < 200) begin
         cnt++;
         @(posedge hclk);
      end
      if (k >= 200 || cnt >= 200) begin
         mismatches++;
         finish_test();
      end else begin
         rd = hrdata;
      end
   endtask
   function logic [31:0] pat(input logic [28:0] la);
      return {~la[17:2], la[17:2]};
   endfunction
   function int ccyc(input logic [7:0] c, input logic sq);
      int t;
      t = sq ? 5 - c[4:3] : (c[2:0] > 5 ? 7 : 7 - c[2:0]);
      return c[5] ? t : 2 * t;
   endfunction
   task cfg_wr(input logic b, input logic [7:0] d);
      xfer(1'b1, b ? romif_pkg::BANK1_CFG_ADDR : romif_pkg::BANK0_CFG_ADDR, {24'h0, d}, r, n);
      cfg[b] = d;
      chain = 1'b0;
   endtask
   task cfg_rd(input logic b);
      xfer(1'b0, b ? romif_pkg::BANK1_CFG_ADDR : romif_pkg::BANK0_CFG_ADDR, 32'h0, r, n);
      chain = 1'b0;
      chk("config", {25'h0, cfg[b][6:0]}, r & 32'h0000_007f);
   endtask
   task rom_read(input logic [31:0] ad);
      logic [31:0] e;
      logic [31:0] lo;
      logic [31:0] hi;
      logic [7:0]  c;
      logic        sq;
      int          t;
      c = cfg[ad[24]];
      sq = c[4:3] != 2'h0 && !c[6] && chain && ad == prev + 32'h4 && ad[3:2] != 2'h0;
      lo = pat({ad[27:2], 3'b000});
      hi = pat({ad[27:2], 3'b100});
      e = c[6] ? ((hi << 16) | (lo & 32'h0000_ffff)) : pat(ad[28:0]);
      t = c[6] ? ccyc(c, 1'b0) + ccyc(c, c[4:3] != 2'h0) + 4 : ccyc(c, sq) + 2;
      xfer(1'b0, ad, 32'h0, r, n);
      chk("rom data", e, r);
      chk("fetch cycles", t, n);
      chain = 1'b1;
      prev = ad;
   endtask
   // ----
   // sequence
   // ----
   initial begin
      seed = 39582;
      {hresetn, hsel, htrans, haddr, hwrite, hwdata, chain, prev} = '0;
      hsize = 3'h2;
      cfg[0] = 8'h40;
      cfg[1] = 8'h40;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      cfg_rd(1'b0);
      cfg_rd(1'b1);
      xfer(1'b0, 32'h0320_00fc, 32'h0, r, n);
      chk("unmapped", 32'h0, r);
      rom_read(32'h0000_0100);
      for (int i = 0; i < 16; i++) begin
         cfg_wr(1'b0, {2'b00, i[3], 2'b00, i[2:0]});
         cfg_rd(1'b0);
         rom_read($random(seed) & 32'h00ff_fffc);
      end
      for (int b = 1; b < 4; b++) begin
         cfg_wr(1'b0, {3'b001, b[1:0], 3'h5});
         for (int k = 0; k < 4; k++) rom_read(32'h40 + 4 * k);
         xfer(1'b0, romif_pkg::FETCH_STAT_ADDR, 32'h0, r, n);
         chain = 1'b0;
         chk("burst status", 32'h30, r);
         rom_read(32'h50);
      end
      for (int i = 0; i < 8; i++) begin
         v = $random(seed);
         cfg_wr(1'b1, {2'b01, v[5:0]});
         rom_read(32'h0100_0000 | ($random(seed) & 32'h00ff_fffc));
      end
      xfer(1'b1, 32'h0000_0040, $random(seed), r, n);
      chain = 1'b0;
      chk("rom write stall", 32'h0, n);
      repeat (40) begin
         v = $random(seed);
         a = $random(seed) & 32'h01ff_fff0;
         if (v[8]) cfg_wr(a[24], {1'b0, v[6:0]});
         rom_read(a);
         if (v[9]) rom_read(a + 32'h4);
      end
      finish_test();
   end
endmodule
bind romif_ctrl romif_ctrl_checker romif_ctrl_checker_inst (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .rom_select_n(rom_select_n));
